// >>> verilog/lsd_level_sensor.sv
// Teach gating, factory reset and level damping of a level sensor
`timescale 1ns/10ps
module lsd_level_sensor #(
    parameter logic [16:0] TICK_CYCLES = lsd_pkg::TICK_CYCLES,
    parameter logic [18:0] WIN_MS      = lsd_pkg::TEACH_WIN_MS,
    parameter logic [26:0] EXT_MS      = lsd_pkg::TEACH_EXT_MS,
    parameter logic [13:0] PRESS_MIN   = lsd_pkg::PRESS_MIN_MS,
    parameter logic [13:0] PRESS_MAX   = lsd_pkg::PRESS_MAX_MS
) (
    input  logic        CLOCK_I,
    input  logic        RESET_N_I,
    input  logic        TEACH_MAGNET_I,
    input  logic [15:0] LEVEL_I,
    input  logic        LEVEL_VALID_I,
    input  logic        IMMERSED_I,
    input  logic        PARAM_WR_I,
    input  logic        PARAM_RD_I,
    input  logic [15:0] PARAM_INDEX_I,
    input  logic [7:0]  PARAM_SUBINDEX_I,
    input  logic [7:0]  PARAM_WDATA_I,
    output logic [7:0]  PARAM_RDATA_O,
    output logic        PARAM_ACK_O,
    output logic        PARAM_ERR_O,
    output logic [15:0] PD_LEVEL_O,
    output logic [7:0]  PD_STATUS_O,
    output logic        PD_VALID_O,
    output logic        LED_GREEN_O,
    output logic        LED_AMBER_O,
    output logic        FACTORY_RESET_O
);
    typedef struct packed {
        logic [16:0]             tick_cnt;
        logic                    ms_tick;
        logic [9:0]              sec_cnt;
        logic                    sec_tick;
        lsd_pkg::lsd_teach_e     state;
        logic [18:0]             win_cnt;
        logic [26:0]             ext_cnt;
        logic [13:0]             held;
        logic                    mag_prev;
        logic                    teach_en;
        logic                    imm_damp;
        logic [5:0]              damp_s;
        logic                    fr;
        logic [11:0]             flash_cnt;
        logic [63:0][15:0]       ring;
        logic [5:0]              wp;
        logic [5:0]              fill;
        logic [21:0]             sum;
        logic [15:0]             last_lvl;
        logic [15:0]             pd_level;
        logic                    pd_valid;
        logic [7:0]              status;
        logic                    green;
        logic                    amber;
        logic [7:0]              rdata;
        logic                    ack;
        logic                    err;
    } lsd_state_s;

    lsd_state_s s_ff;
    lsd_state_s nxt_s;
    logic       rst_meta_ff;
    logic       rst_n_ff;
    logic       teach_open;
    logic       press_start;

    default clocking cb_sva @(posedge CLOCK_I);
    endclocking
    default disable iff (!rst_n_ff);

    // Parameter address match
    function automatic logic lsd_hit(input logic [15:0] idx, input logic [7:0] sub,
                                     input logic [15:0] want_idx, input logic [7:0] want_sub);
        return (idx == want_idx) && (sub == want_sub);
    endfunction

    // Reciprocal scaled by 2^22, saves a divider per average
    function automatic logic [22:0] lsd_recip(input logic [5:0] n);
        return (n == 6'h00) ? 23'h000000 : 23'(23'h400000 / {17'h00000, n});
    endfunction

    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    assign teach_open  = s_ff.teach_en && (s_ff.state != lsd_pkg::T_LOCKED);
    assign press_start = TEACH_MAGNET_I && !s_ff.mag_prev && teach_open;

    always_comb begin
        logic        fr_req;
        logic        undamped;
        logic [15:0] old_lvl;
        logic [44:0] prod;
        logic [11:0] flash_left;
        fr_req   = 1'b0;
        flash_left = 12'h000;
        undamped = 1'b0;
        old_lvl  = 16'h0000;
        prod     = 45'h0;
        nxt_s    = s_ff;
        nxt_s.ms_tick  = 1'b0;
        nxt_s.sec_tick = 1'b0;
        nxt_s.ack      = 1'b0;
        nxt_s.err      = 1'b0;
        nxt_s.fr       = 1'b0;
        nxt_s.pd_valid = 1'b0;
        // Millisecond and second enables
        if (s_ff.tick_cnt == TICK_CYCLES - 17'h1) begin
            nxt_s.tick_cnt = 17'h0;
            nxt_s.ms_tick  = 1'b1;
        end else begin
            nxt_s.tick_cnt = s_ff.tick_cnt + 17'h1;
        end
        if (s_ff.ms_tick) begin
            if (s_ff.sec_cnt == lsd_pkg::SEC_MS - 10'h1) begin
                nxt_s.sec_cnt  = 10'h0;
                nxt_s.sec_tick = 1'b1;
            end else begin
                nxt_s.sec_cnt = s_ff.sec_cnt + 10'h1;
            end
        end
        // Teach availability timers
        unique case (s_ff.state)
            lsd_pkg::T_WINDOW: begin
                if (press_start) begin
                    nxt_s.state   = lsd_pkg::T_EXTENDED;
                    nxt_s.ext_cnt = 27'h0;
                end else if (s_ff.ms_tick) begin
                    if (s_ff.win_cnt == WIN_MS - 19'h1) begin
                        nxt_s.state = lsd_pkg::T_LOCKED;
                    end else begin
                        nxt_s.win_cnt = s_ff.win_cnt + 19'h1;
                    end
                end
            end
            lsd_pkg::T_EXTENDED: begin
                if (s_ff.ms_tick) begin
                    if (s_ff.ext_cnt == EXT_MS - 27'h1) begin
                        nxt_s.state = lsd_pkg::T_LOCKED;
                    end else begin
                        nxt_s.ext_cnt = s_ff.ext_cnt + 27'h1;
                    end
                end
            end
            lsd_pkg::T_LOCKED: begin
            end
            default: nxt_s.state = lsd_pkg::T_LOCKED;
        endcase
        // Press length; judged on release so a longer hold does nothing
        nxt_s.mag_prev = TEACH_MAGNET_I;
        if (TEACH_MAGNET_I && teach_open) begin
            if (s_ff.ms_tick && (s_ff.held != 14'h3FFF)) begin
                nxt_s.held = s_ff.held + 14'h1;
            end
        end else begin
            nxt_s.held = 14'h0;
        end
        if (s_ff.mag_prev && !TEACH_MAGNET_I && teach_open &&
            (s_ff.held >= PRESS_MIN) && (s_ff.held <= PRESS_MAX)) begin
            fr_req = 1'b1;
        end
        nxt_s.green = TEACH_MAGNET_I && teach_open;
        // Damping, one sample per second in a ring
        if (LEVEL_VALID_I) begin
            nxt_s.last_lvl = LEVEL_I;
        end
        undamped = (s_ff.damp_s == 6'h00) || (IMMERSED_I && !s_ff.imm_damp);
        if (undamped && LEVEL_VALID_I) begin
            nxt_s.pd_level = LEVEL_I;
            nxt_s.pd_valid = 1'b1;
        end
        if (s_ff.sec_tick && (s_ff.damp_s != 6'h00)) begin
            if (s_ff.fill == s_ff.damp_s) begin
                old_lvl = s_ff.ring[6'(s_ff.wp - s_ff.damp_s)];
            end
            nxt_s.sum = 22'(s_ff.sum + {6'h00, s_ff.last_lvl} - {6'h00, old_lvl});
            nxt_s.ring[s_ff.wp] = s_ff.last_lvl;
            nxt_s.wp = s_ff.wp + 6'h1;
            if (s_ff.fill != s_ff.damp_s) begin
                nxt_s.fill = s_ff.fill + 6'h1;
            end
            prod = {23'h0, nxt_s.sum} * {22'h0, lsd_recip(nxt_s.fill)} + 45'h200000;
            if (!undamped) begin
                nxt_s.pd_level = prod[37:22];
                nxt_s.pd_valid = 1'b1;
            end
        end
        // Acyclic parameter access
        if (PARAM_WR_I) begin
            nxt_s.ack = 1'b1;
            if (lsd_hit(PARAM_INDEX_I, PARAM_SUBINDEX_I, lsd_pkg::IDX_SYS_CMD,
                        lsd_pkg::SUB_SYS_CMD)) begin
                if (PARAM_WDATA_I == lsd_pkg::CMD_FACTORY_RST) begin
                    fr_req = 1'b1;
                end else begin
                    nxt_s.err = 1'b1;
                end
            end else if (lsd_hit(PARAM_INDEX_I, PARAM_SUBINDEX_I, lsd_pkg::IDX_DAMPING,
                                 lsd_pkg::SUB_DAMP_TIME)) begin
                if (PARAM_WDATA_I <= {2'h0, lsd_pkg::DAMP_MAX_S}) begin
                    nxt_s.damp_s = PARAM_WDATA_I[5:0];
                    nxt_s.fill   = 6'h00;
                    nxt_s.sum    = 22'h0;
                end else begin
                    nxt_s.err = 1'b1;
                end
            end else if (lsd_hit(PARAM_INDEX_I, PARAM_SUBINDEX_I, lsd_pkg::IDX_DAMPING,
                                 lsd_pkg::SUB_DAMP_IMM) && (PARAM_WDATA_I[7:1] == 7'h00)) begin
                nxt_s.imm_damp = PARAM_WDATA_I[0];
            end else if (lsd_hit(PARAM_INDEX_I, PARAM_SUBINDEX_I, lsd_pkg::IDX_TEACH,
                                 lsd_pkg::SUB_TEACH_EN) && (PARAM_WDATA_I[7:1] == 7'h00)) begin
                nxt_s.teach_en = PARAM_WDATA_I[0];
            end else begin
                nxt_s.err = 1'b1;
            end
        end else if (PARAM_RD_I) begin
            nxt_s.ack   = 1'b1;
            nxt_s.rdata = 8'h00;
            if (lsd_hit(PARAM_INDEX_I, PARAM_SUBINDEX_I, lsd_pkg::IDX_DAMPING,
                        lsd_pkg::SUB_DAMP_TIME)) begin
                nxt_s.rdata = {2'h0, s_ff.damp_s};
            end else if (lsd_hit(PARAM_INDEX_I, PARAM_SUBINDEX_I, lsd_pkg::IDX_DAMPING,
                                 lsd_pkg::SUB_DAMP_IMM)) begin
                nxt_s.rdata = {7'h00, s_ff.imm_damp};
            end else if (lsd_hit(PARAM_INDEX_I, PARAM_SUBINDEX_I, lsd_pkg::IDX_TEACH,
                                 lsd_pkg::SUB_TEACH_EN)) begin
                nxt_s.rdata = {7'h00, s_ff.teach_en};
            end else begin
                nxt_s.err = 1'b1;
            end
        end
        // Factory reset last, so it beats a write in the same cycle
        if (fr_req) begin
            nxt_s.fr        = 1'b1;
            nxt_s.teach_en  = lsd_pkg::TEACH_EN_DEF;
            nxt_s.imm_damp  = lsd_pkg::IMM_DAMP_DEF;
            nxt_s.damp_s    = lsd_pkg::DAMP_DEF_S;
            nxt_s.fill      = 6'h00;
            nxt_s.sum       = 22'h0;
            nxt_s.flash_cnt = lsd_pkg::FLASH_MS;
        end else if (s_ff.ms_tick && (s_ff.flash_cnt != 12'h000)) begin
            nxt_s.flash_cnt = s_ff.flash_cnt - 12'h001;
        end
        // Judged on count minus one, so the full count starts a lit phase, not a dark one
        flash_left   = nxt_s.flash_cnt - 12'h001;
        nxt_s.amber  = (nxt_s.flash_cnt != 12'h000) && flash_left[lsd_pkg::BLINK_BIT];
        nxt_s.status = {3'h0, nxt_s.amber, nxt_s.green, !undamped, teach_open,
                        IMMERSED_I};
    end

    always_ff @(posedge CLOCK_I or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            s_ff          <= '0;
            s_ff.state    <= lsd_pkg::T_WINDOW;
            s_ff.teach_en <= lsd_pkg::TEACH_EN_DEF;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign PARAM_RDATA_O   = s_ff.rdata;
    assign PARAM_ACK_O     = s_ff.ack;
    assign PARAM_ERR_O     = s_ff.err;
    assign PD_LEVEL_O      = s_ff.pd_level;
    assign PD_STATUS_O     = s_ff.status;
    assign PD_VALID_O      = s_ff.pd_valid;
    assign LED_GREEN_O     = s_ff.green;
    assign LED_AMBER_O     = s_ff.amber;
    assign FACTORY_RESET_O = s_ff.fr;

    property p_cfg_teach_off;
        PARAM_WR_I && (PARAM_WDATA_I == 8'h00) &&
        lsd_hit(PARAM_INDEX_I, PARAM_SUBINDEX_I, lsd_pkg::IDX_TEACH, lsd_pkg::SUB_TEACH_EN)
        |=> !s_ff.teach_en || FACTORY_RESET_O;
    endproperty
    a_cfg_teach_off: assert property (p_cfg_teach_off) else $error("teach not off");
    property p_window_expiry;
        (s_ff.state == lsd_pkg::T_WINDOW) && s_ff.ms_tick &&
        (s_ff.win_cnt == WIN_MS - 19'h1) && !press_start
        |=> (s_ff.state == lsd_pkg::T_LOCKED) ##1 !PD_STATUS_O[1];
    endproperty
    a_window_expiry: assert property (p_window_expiry) else $error("window open");
    property p_extend;
        (s_ff.state == lsd_pkg::T_WINDOW) && press_start
        |=> (s_ff.state == lsd_pkg::T_EXTENDED) && (s_ff.ext_cnt == 27'h0);
    endproperty
    a_extend: assert property (p_extend) else $error("no extension");
    property p_green;
        TEACH_MAGNET_I && teach_open |=> LED_GREEN_O;
    endproperty
    a_green: assert property (p_green) else $error("lamp dark");
    property p_press_reset;
        s_ff.mag_prev && !TEACH_MAGNET_I && teach_open && (s_ff.held >= PRESS_MIN) &&
        (s_ff.held <= PRESS_MAX) |=> FACTORY_RESET_O ##1 !FACTORY_RESET_O;
    endproperty
    a_press_reset: assert property (p_press_reset) else $error("press missed");
    property p_amber;
        FACTORY_RESET_O |-> LED_AMBER_O && (s_ff.flash_cnt == lsd_pkg::FLASH_MS);
    endproperty
    a_amber: assert property (p_amber) else $error("no amber");
    property p_cmd_reset;
        PARAM_WR_I && (PARAM_WDATA_I == lsd_pkg::CMD_FACTORY_RST) &&
        lsd_hit(PARAM_INDEX_I, PARAM_SUBINDEX_I, lsd_pkg::IDX_SYS_CMD, lsd_pkg::SUB_SYS_CMD)
        |=> FACTORY_RESET_O && PARAM_ACK_O && !PARAM_ERR_O;
    endproperty
    a_cmd_reset: assert property (p_cmd_reset) else $error("command ignored");
    property p_defaults;
        FACTORY_RESET_O |-> (s_ff.teach_en == lsd_pkg::TEACH_EN_DEF) &&
        (s_ff.imm_damp == lsd_pkg::IMM_DAMP_DEF) && (s_ff.damp_s == lsd_pkg::DAMP_DEF_S);
    endproperty
    a_defaults: assert property (p_defaults) else $error("not defaulted");
    property p_damp_range;
        (s_ff.damp_s <= lsd_pkg::DAMP_MAX_S) && (s_ff.fill <= s_ff.damp_s);
    endproperty
    a_damp_range: assert property (p_damp_range) else $error("damping range");
    property p_passthru;
        LEVEL_VALID_I && (s_ff.damp_s == 6'h00) && !PARAM_WR_I
        |=> PD_VALID_O && (PD_LEVEL_O == $past(LEVEL_I));
    endproperty
    a_passthru: assert property (p_passthru) else $error("no passthrough");
endmodule // lsd_level_sensor

// >>> verilog/lsd_pkg.sv
// Constants for the level sensor teach, factory reset and damping block
package lsd_pkg;
    // Clock and time base
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          TICK_NS         = 1000000;
    localparam logic [16:0] TICK_CYCLES     = 17'(TICK_NS / CLK_PERIOD_NS);
    localparam logic [9:0]  SEC_MS          = 10'(1000);
    // Teach timing, in the printed units
    localparam int          TEACH_WIN_MIN   = 5;
    localparam int          TEACH_EXT_H     = 24;
    localparam int          PRESS_MIN_S     = 9;
    localparam int          PRESS_MAX_S     = 12;
    localparam logic [18:0] TEACH_WIN_MS    = 19'(TEACH_WIN_MIN * 60 * 1000);
    localparam logic [26:0] TEACH_EXT_MS    = 27'(TEACH_EXT_H * 3600 * 1000);
    localparam logic [13:0] PRESS_MIN_MS    = 14'(PRESS_MIN_S * 1000);
    localparam logic [13:0] PRESS_MAX_MS    = 14'(PRESS_MAX_S * 1000);
    // Amber flash after a factory reset
    localparam logic [11:0] FLASH_MS        = 12'h800;
    localparam int          BLINK_BIT       = 8;
    // Damping
    localparam logic [5:0]  DAMP_MAX_S      = 6'h3C;
    localparam logic [5:0]  DAMP_DEF_S      = 6'h00;
    // Parameter map (index, subindex) and values
    localparam logic [15:0] IDX_SYS_CMD     = 16'h0002;
    localparam logic [7:0]  SUB_SYS_CMD     = 8'h00;
    localparam logic [7:0]  CMD_FACTORY_RST = 8'h82;
    localparam logic [15:0] IDX_DAMPING     = 16'h0079;
    localparam logic [7:0]  SUB_DAMP_TIME   = 8'h02;
    localparam logic [7:0]  SUB_DAMP_IMM    = 8'h01;
    localparam logic [15:0] IDX_TEACH       = 16'h003A;
    localparam logic [7:0]  SUB_TEACH_EN    = 8'h01;
    // Defaults of user settings
    localparam logic        TEACH_EN_DEF    = 1'b1;
    localparam logic        IMM_DAMP_DEF    = 1'b0;

    typedef enum logic [2:0] {
        T_WINDOW   = 3'b001,
        T_EXTENDED = 3'b010,
        T_LOCKED   = 3'b100
    } lsd_teach_e;
endpackage

// >>> sim/lsd_master_model.sv
// Behavioural IO-Link master and magnet tool facing the sensor block
`timescale 1ns/10ps
module lsd_master_model (
    input  wire logic        clock_i,
    input  wire logic        param_ack_i,
    input  wire logic        param_err_i,
    input  wire logic [7:0]  param_rdata_i,
    output logic             param_wr_o,
    output logic             param_rd_o,
    output logic [15:0]      param_index_o,
    output logic [7:0]       param_subindex_o,
    output logic [7:0]       param_wdata_o,
    output logic             teach_magnet_o
);
    initial begin
        param_wr_o       = 1'b0;
        param_rd_o       = 1'b0;
        param_index_o    = 16'h0000;
        param_subindex_o = 8'h00;
        param_wdata_o    = 8'h00;
        teach_magnet_o   = 1'b0;
    end

    // One byte per acyclic access, strobe up for one taking edge
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [7:0] wd, output logic ack, output logic err,
                          output logic [7:0] rd);
        @(posedge clock_i);
        param_wr_o       <= wr;
        param_rd_o       <= ~wr;
        param_index_o    <= idx;
        param_subindex_o <= sub;
        param_wdata_o    <= wd;
        @(posedge clock_i);
        param_wr_o       <= 1'b0;
        param_rd_o       <= 1'b0;
        // Released lines carry junk so stale values never pass
        param_index_o    <= ~idx;
        param_subindex_o <= ~sub;
        param_wdata_o    <= ~wd;
        @(posedge clock_i);
        ack = param_ack_i;
        err = param_err_i;
        rd  = param_rdata_i;
    endtask

    // Magnet placed or lifted; hold time is the caller's choice
    task automatic magnet(input logic level);
        @(posedge clock_i);
        teach_magnet_o <= level;
    endtask
endmodule // lsd_master_model

// >>> sim/lsd_tb_top.sv
// Self-checking bench for teach gating, factory reset and damping
`timescale 1ns/10ps
module level_sensor_teach_damping_tb_top;
    typedef struct packed {
        logic        wr;
        logic [15:0] idx;
        logic [7:0]  sub;
        logic [7:0]  wd;
        logic        err;
        logic [7:0]  rd;
    } lsd_row_s;

    logic        clk, rst_n, lvl_vld, immersed, magnet, wr, rd, ack, err;
    logic        pd_valid, green, amber, frst, a_ack, a_err;
    logic [15:0] lvl, idx, pd_level;
    logic [7:0]  sub, wd, rdata, pd_status, a_rd;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    lsd_row_s    rows [13] = '{
        '{1'b0, 16'h003A, 8'h01, 8'h00, 1'b0, 8'h01}, '{1'b0, 16'h0079, 8'h02, 8'h00, 1'b0, 8'h00},
        '{1'b0, 16'h0079, 8'h01, 8'h00, 1'b0, 8'h00}, '{1'b0, 16'h0002, 8'h00, 8'h00, 1'b1, 8'h00},
        '{1'b0, 16'h0005, 8'h00, 8'h00, 1'b1, 8'h00}, '{1'b1, 16'h0079, 8'h02, 8'h3D, 1'b1, 8'h00},
        '{1'b1, 16'h0079, 8'h02, 8'h3C, 1'b0, 8'h00}, '{1'b0, 16'h0079, 8'h02, 8'h00, 1'b0, 8'h3C},
        '{1'b1, 16'h0079, 8'h01, 8'h02, 1'b1, 8'h00}, '{1'b1, 16'h0002, 8'h00, 8'h81, 1'b1, 8'h00},
        '{1'b1, 16'h003A, 8'h01, 8'h02, 1'b1, 8'h00}, '{1'b1, 16'h003A, 8'h01, 8'h00, 1'b0, 8'h00},
        '{1'b0, 16'h003A, 8'h01, 8'h00, 1'b0, 8'h00}};

    // Short time base so every teach timer runs out inside the run
    localparam logic [16:0] sim_tick      = 17'h00004;
    localparam logic [18:0] sim_win       = 19'h00032;
    localparam logic [26:0] sim_ext       = 27'h0000064;
    localparam logic [13:0] sim_press_min = 14'h0009;
    localparam logic [13:0] sim_press_max = 14'h000C;

    lsd_level_sensor #(.TICK_CYCLES(sim_tick), .WIN_MS(sim_win), .EXT_MS(sim_ext),
                       .PRESS_MIN(sim_press_min), .PRESS_MAX(sim_press_max)) uut (
        .CLOCK_I(clk), .RESET_N_I(rst_n), .TEACH_MAGNET_I(magnet), .LEVEL_I(lvl),
        .LEVEL_VALID_I(lvl_vld), .IMMERSED_I(immersed), .PARAM_WR_I(wr), .PARAM_RD_I(rd),
        .PARAM_INDEX_I(idx), .PARAM_SUBINDEX_I(sub), .PARAM_WDATA_I(wd), .PARAM_RDATA_O(rdata),
        .PARAM_ACK_O(ack), .PARAM_ERR_O(err), .PD_LEVEL_O(pd_level), .PD_STATUS_O(pd_status),
        .PD_VALID_O(pd_valid), .LED_GREEN_O(green), .LED_AMBER_O(amber), .FACTORY_RESET_O(frst));

    lsd_master_model mdl (
        .clock_i(clk), .param_ack_i(ack), .param_err_i(err), .param_rdata_i(rdata),
        .param_wr_o(wr), .param_rd_o(rd), .param_index_o(idx), .param_subindex_o(sub),
        .param_wdata_o(wd), .teach_magnet_o(magnet));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole run needs roughly 13000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                       input logic [7:0] d, input logic e, input logic [7:0] r);
        mdl.access(w, i, s, d, a_ack, a_err, a_rd);
        chk(a_ack, 1'b1);
        chk(a_err, e);
        if (!w && !e) chk(a_rd, r);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Two synchroniser edges, one edge to load the first live state, then one spare edge
        repeat (4) @(posedge clk);
    endtask

    // New level sample; outputs of the answer cycle are readable on return
    task automatic sample(input logic [15:0] v);
        @(posedge clk);
        lvl     <= v;
        lvl_vld <= 1'b1;
        @(posedge clk);
        lvl     <= ~v;
        lvl_vld <= 1'b0;
        @(posedge clk);
    endtask

    // Damped output comes once a second, 4000 cycles at the short tick
    task automatic wait_pd(input logic [15:0] exp);
        for (int n = 0; n < 4200; n++) begin
            @(posedge clk);
            if (pd_valid === 1'b1) break;
        end
        chk(pd_valid, 1'b1);
        chk(pd_level, exp);
    endtask

    task automatic press(input int n, input logic exp_green, input logic exp_rst);
        logic seen;
        seen = 1'b0;
        mdl.magnet(1'b1);
        repeat (3) @(posedge clk);
        chk(green, exp_green);
        repeat (n - 3) @(posedge clk);
        mdl.magnet(1'b0);
        repeat (4) begin
            @(posedge clk);
            seen = seen | frst;
        end
        chk(seen, exp_rst);
    endtask

    initial begin
        rst_n    = 1'b0;
        lvl_vld  = 1'b0;
        lvl      = 16'h0000;
        immersed = 1'b0;
        do_reset();
        chk(pd_level, 16'h0000);
        foreach (rows[i]) acc(rows[i].wr, rows[i].idx, rows[i].sub, rows[i].wd, rows[i].err,
                              rows[i].rd);
        press(8, 1'b0, 1'b0);
        acc(1'b1, 16'h003A, 8'h01, 8'h01, 1'b0, 8'h00);
        press(42, 1'b1, 1'b1);
        chk(amber, 1'b1);
        chk(pd_status[4], 1'b1);
        press(60, 1'b1, 1'b0);
        acc(1'b1, 16'h0079, 8'h02, 8'h00, 1'b0, 8'h00);
        sample(16'h1234);
        chk(pd_valid, 1'b1);
        chk(pd_level, 16'h1234);
        immersed <= 1'b1;
        acc(1'b1, 16'h0079, 8'h02, 8'h02, 1'b0, 8'h00);
        sample(16'h0ABC);
        chk(pd_level, 16'h0ABC);
        chk(pd_status[0], 1'b1);
        acc(1'b1, 16'h0079, 8'h01, 8'h01, 1'b0, 8'h00);
        sample(16'h0064);
        chk(pd_valid, 1'b0);
        chk(pd_status, 16'h0017);
        acc(1'b1, 16'h0079, 8'h02, 8'h02, 1'b0, 8'h00);
        wait_pd(16'h0064);
        sample(16'h00C8);
        wait_pd(16'h0096);
        wait_pd(16'h00C8);
        immersed <= 1'b0;
        acc(1'b1, 16'h003A, 8'h01, 8'h00, 1'b0, 8'h00);
        chk(pd_status[0], 1'b0);
        acc(1'b1, 16'h0002, 8'h00, 8'h82, 1'b0, 8'h00);
        chk(frst, 1'b1);
        chk(amber, 1'b1);
        acc(1'b0, 16'h0079, 8'h02, 8'h00, 1'b0, 8'h00);
        acc(1'b0, 16'h0079, 8'h01, 8'h00, 1'b0, 8'h00);
        acc(1'b0, 16'h003A, 8'h01, 8'h00, 1'b0, 8'h01);
        do_reset();
        chk(pd_status[1], 1'b1);
        repeat (260) @(posedge clk);
        chk(pd_status[1], 1'b0);
        press(8, 1'b0, 1'b0);
        do_reset();
        press(8, 1'b1, 1'b0);
        repeat (280) @(posedge clk);
        press(8, 1'b1, 1'b0);
        repeat (300) @(posedge clk);
        press(8, 1'b0, 1'b0);
        summarize();
    end
endmodule // level_sensor_teach_damping_tb_top
